// ### hdl/rlc_pkg.sv
// Package: register map, field layouts, types and timing for the record level control
package rlc_pkg;

  // ----------------------------------------------------------------
  // Register map (word offsets, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] RLC_GAIN_L_ADDR = 8'h00;
  localparam logic [7:0] RLC_GAIN_R_ADDR = 8'h04;
  localparam logic [7:0] RLC_CTRL1_ADDR = 8'h08;
  localparam logic [7:0] RLC_CTRL2_ADDR = 8'h0c;
  localparam logic [7:0] RLC_CTRL3_ADDR = 8'h10;
  localparam logic [7:0] RLC_ADCCTL_ADDR = 8'h14;
  localparam logic [7:0] RLC_STATUS_ADDR = 8'h18;
  localparam logic [7:0] RLC_APPLIED_ADDR = 8'h1c;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int RLC_GAIN_W = 6;
  localparam logic [RLC_GAIN_W-1:0] RLC_GAIN_MAX = 6'h30;
  localparam logic [RLC_GAIN_W-1:0] RLC_GAIN_MIN = 6'h00;
  localparam int RLC_LVL_W = 23;
  localparam int RLC_THR_W = 8;
  localparam int RLC_THR_SHIFT = RLC_LVL_W - RLC_THR_W;
  localparam int RLC_CNT_W = 4;
  localparam int RLC_TSEL_W = 2;
  localparam int RLC_C1_EN = 0;
  localparam int RLC_C1_BOTH = 1;
  localparam int RLC_C1_MODE_LO = 2;
  localparam int RLC_C1_CNT_LO = 4;
  localparam int RLC_C1_ATK_LO = 8;
  localparam int RLC_C1_REC_LO = 10;
  localparam int RLC_C2_ATK_LO = 0;
  localparam int RLC_C2_REC_LO = 8;
  localparam int RLC_AC_QUARTER = 0;

  typedef enum logic [1:0] {
    RLC_REC_NONE = 2'h0,
    RLC_REC_NORMAL = 2'h1,
    RLC_REC_LIMITED = 2'h2
  } rlc_rec_t;

  typedef enum logic [2:0] {
    RLC_ST_IDLE = 3'h1,
    RLC_ST_ATTACK = 3'h2,
    RLC_ST_RECOVER = 3'h4
  } rlc_state_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RLC_OSR = 256;
  localparam int RLC_DIV_W = 8;
  localparam int RLC_MOD_W = 2;
  localparam logic [RLC_MOD_W-1:0] RLC_MOD_HALF = 2'h1;
  localparam logic [RLC_MOD_W-1:0] RLC_MOD_QUARTER = 2'h3;
  localparam int RLC_TMR_W = 16;
  // Interval counts in output samples, indexed by 2-bit timer fields
  localparam logic [RLC_TMR_W-1:0] RLC_ATK_SAMPLES [4] = '{16'h0030, 16'h0018, 16'h000c, 16'h0006};
  localparam logic [RLC_TMR_W-1:0] RLC_REC_SAMPLES [4] = '{16'h0c00, 16'h0600, 16'h0300, 16'h0180};

  typedef struct packed {
    logic [RLC_GAIN_W-1:0] left;
    logic [RLC_GAIN_W-1:0] right;
  } rlc_gain_pair_t;

  typedef struct packed {
    logic [RLC_LVL_W-1:0] left;
    logic [RLC_LVL_W-1:0] right;
  } rlc_level_t;

endpackage

// ### hdl/rlc_top.sv
// Record level control: gain attack/recovery, modulator rate, Wishbone registers
// Behaviour
// R1: Output above attack threshold starts attack, both gains drop one step.
// R2: After each step wait attack interval, resample, step again while above.
// R3: One common offset subtracted from both initial gains keeps their difference.
// R4: Applied gain never exceeds the channel's initial programmed gain.
// R5: Detect-both bit set needs both channels over; clear needs either.
// R6: No-recovery mode keeps reduced gain until level control reset.
// R7: Enable toggled off/on or any write to control 3 resets the function; here a control 3 write needs byte lane 0 selected.
// R8: Normal recovery raises one step per recovery interval below threshold.
// R9: Above recovery threshold during recovery, hold gain until below again.
// R10: Fully restored gain stays put until attack threshold exceeded again.
// R11: Limited recovery counts intervals with any recovery-threshold excursion.
// R12: Counter at its programmed maximum stops further recovery.
// R13: Attack excursion in limited recovery restarts attack, clears counter.
// R14: Output sample strobe is master clock divided by 256 always.
// R15: Modulator runs at half master clock, quarter when select bit set.
// R16: Quarter modulator rate selects the alternative decimator filter set.
// R17: While enabled, writes to gain or level settings are ignored.
// R18: Gain setting spans 0 to 24 dB in 0.5 dB codes per channel.
// R19: Attack saturates at lowest gain code, never below.
//
// Our own choices: the address map and the Wishbone slave port.
module rlc_top
  import rlc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SAMPLE_VALID,
  input wire rlc_level_t SAMPLE_LEVEL,
  output rlc_gain_pair_t PGA_GAIN,
  output logic SAMPLE_STROBE,
  output logic MOD_CLK_EN,
  output logic DECIM_ALT_FILTER
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    rlc_gain_pair_t init;
    rlc_gain_pair_t gain;
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic quarter;
    logic en_prev;
    rlc_state_t state;
    logic [RLC_TMR_W-1:0] tmr;
    logic [RLC_CNT_W-1:0] exc_cnt;
    logic exc_seen;
    logic [RLC_DIV_W-1:0] div;
    logic [RLC_MOD_W-1:0] mdiv;
    logic sstrobe;
    logic mod_en;
  } rlc_regs_t;

  rlc_regs_t r_reg;
  rlc_regs_t r_next;

  // ----------------------------------------------------------------
  // Decoded control fields
  // ----------------------------------------------------------------
  logic enable;
  logic detect_both;
  rlc_rec_t rec_mode;
  logic [RLC_CNT_W-1:0] cnt_max;
  logic [RLC_TSEL_W-1:0] atk_sel;
  logic [RLC_TSEL_W-1:0] rec_sel;
  logic [RLC_LVL_W-1:0] atk_thr;
  logic [RLC_LVL_W-1:0] rec_thr;
  logic over_atk_l;
  logic over_atk_r;
  logic over_atk;
  logic over_rec;
  logic req;
  logic wr;
  logic at_ceiling;
  logic [RLC_GAIN_W-1:0] offset;

  assign enable = r_reg.ctrl1[RLC_C1_EN];
  assign detect_both = r_reg.ctrl1[RLC_C1_BOTH];
  assign rec_mode = rlc_rec_t'(r_reg.ctrl1[RLC_C1_MODE_LO +: 2]);
  assign cnt_max = r_reg.ctrl1[RLC_C1_CNT_LO +: RLC_CNT_W];
  assign atk_sel = r_reg.ctrl1[RLC_C1_ATK_LO +: RLC_TSEL_W];
  assign rec_sel = r_reg.ctrl1[RLC_C1_REC_LO +: RLC_TSEL_W];
  // Thresholds are the top bits of the magnitude, low bits padded with zero
  assign atk_thr = {r_reg.ctrl2[RLC_C2_ATK_LO +: RLC_THR_W], {RLC_THR_SHIFT{1'b0}}};
  assign rec_thr = {r_reg.ctrl2[RLC_C2_REC_LO +: RLC_THR_W], {RLC_THR_SHIFT{1'b0}}};

  assign over_atk_l = SAMPLE_LEVEL.left > atk_thr;
  assign over_atk_r = SAMPLE_LEVEL.right > atk_thr;
  assign over_atk = SAMPLE_VALID &&
    (detect_both ? (over_atk_l && over_atk_r) : (over_atk_l || over_atk_r)); // R5
  assign over_rec = SAMPLE_VALID &&
    (SAMPLE_LEVEL.left > rec_thr || SAMPLE_LEVEL.right > rec_thr);
  // Offset is the one value subtracted from both, so the gap is unchanged
  assign offset = r_reg.init.left - r_reg.gain.left; // R3
  assign at_ceiling = (offset == RLC_GAIN_MIN);

  assign req = WB_CYC_I && WB_STB_I && !r_reg.ack;
  // Writes land at the edge that samples ack high, not at the taking edge
  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && r_reg.ack;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic restart;
    logic [RLC_GAIN_W-1:0] wgain;
    restart = 1'b0;
    wgain = RLC_GAIN_MIN;
    r_next = r_reg;
    r_next.ack = req;
    r_next.rdata = '0;

    // Bus reads
    if (req && !WB_WE_I) begin
      case (WB_ADR_I)
        RLC_GAIN_L_ADDR: r_next.rdata = 32'(r_reg.init.left);
        RLC_GAIN_R_ADDR: r_next.rdata = 32'(r_reg.init.right);
        RLC_CTRL1_ADDR: r_next.rdata = 32'(r_reg.ctrl1);
        RLC_CTRL2_ADDR: r_next.rdata = 32'(r_reg.ctrl2);
        RLC_ADCCTL_ADDR: r_next.rdata = 32'(r_reg.quarter);
        RLC_STATUS_ADDR: r_next.rdata = {24'h000000, r_reg.exc_cnt, 1'b0, r_reg.state};
        RLC_APPLIED_ADDR: r_next.rdata = 32'({r_reg.gain.left, 2'h0, r_reg.gain.right});
        default: r_next.rdata = 32'h00000000;
      endcase
    end

    // Bus writes; low byte lanes carry every field
    if (wr && WB_SEL_I[0]) begin
      wgain = (WB_DAT_I[RLC_GAIN_W-1:0] > RLC_GAIN_MAX) ? RLC_GAIN_MAX
        : WB_DAT_I[RLC_GAIN_W-1:0]; // R18
      case (WB_ADR_I)
        RLC_GAIN_L_ADDR: begin
          if (!enable) r_next.init.left = wgain; // R17
        end
        RLC_GAIN_R_ADDR: begin
          if (!enable) r_next.init.right = wgain; // R17
        end
        RLC_CTRL1_ADDR: begin
          // Only the enable bit may change while enabled
          if (!enable) r_next.ctrl1[7:0] = WB_DAT_I[7:0]; // R17
          else r_next.ctrl1[RLC_C1_EN] = WB_DAT_I[RLC_C1_EN];
        end
        RLC_CTRL2_ADDR: begin
          if (!enable) r_next.ctrl2[7:0] = WB_DAT_I[7:0]; // R17
        end
        RLC_CTRL3_ADDR: restart = 1'b1; // R7
        RLC_ADCCTL_ADDR: r_next.quarter = WB_DAT_I[RLC_AC_QUARTER]; // R15
        default: begin
        end
      endcase
    end
    if (wr && WB_SEL_I[1] && !enable) begin
      case (WB_ADR_I)
        RLC_CTRL1_ADDR: r_next.ctrl1[15:8] = WB_DAT_I[15:8]; // R17
        RLC_CTRL2_ADDR: r_next.ctrl2[15:8] = WB_DAT_I[15:8]; // R17
        default: begin
        end
      endcase
    end

    // Clock generation: sample strobe every 256 clocks, modulator 1/2 or 1/4
    r_next.div = r_reg.div + 1'b1; // R14
    r_next.sstrobe = (r_reg.div == RLC_DIV_W'(RLC_OSR - 1)); // R14
    r_next.mdiv = r_reg.mdiv + 1'b1;
    r_next.mod_en = ((r_reg.mdiv & (r_reg.quarter ? RLC_MOD_QUARTER : RLC_MOD_HALF))
      == (r_reg.quarter ? RLC_MOD_QUARTER : RLC_MOD_HALF)); // R15

    // Rising edge of enable restarts as well as a control 3 write
    r_next.en_prev = enable;
    if (enable && !r_reg.en_prev) restart = 1'b1; // R7

    if (restart || !enable) begin
      // Track the new initial value so a lowered ceiling is never overshot
      r_next.gain = r_next.init; // R7 R4
      r_next.state = RLC_ST_IDLE;
      r_next.tmr = '0;
      r_next.exc_cnt = '0;
      r_next.exc_seen = 1'b0;
    end else begin
      if (r_reg.tmr != '0 && SAMPLE_VALID) r_next.tmr = r_reg.tmr - 1'b1;
      case (r_reg.state)
        RLC_ST_IDLE, RLC_ST_RECOVER: begin
          if (over_atk) begin
            // Enter attack; common step keeps L/R difference
            if (r_reg.gain.left != RLC_GAIN_MIN && r_reg.gain.right != RLC_GAIN_MIN) begin
              r_next.gain.left = r_reg.gain.left - 1'b1; // R1
              r_next.gain.right = r_reg.gain.right - 1'b1; // R1
            end // R19
            r_next.state = RLC_ST_ATTACK;
            r_next.tmr = RLC_ATK_SAMPLES[atk_sel]; // R2
            r_next.exc_cnt = '0; // R13
            r_next.exc_seen = 1'b0;
          end else if (r_reg.state == RLC_ST_RECOVER) begin
            if (over_rec) r_next.exc_seen = 1'b1; // R9 R11
            if (r_reg.tmr == '0) begin
              r_next.tmr = RLC_REC_SAMPLES[rec_sel];
              r_next.exc_seen = 1'b0;
              if (rec_mode == RLC_REC_LIMITED && (r_reg.exc_seen || over_rec))
                r_next.exc_cnt = r_reg.exc_cnt + 1'b1; // R11
              if (at_ceiling) begin
                r_next.state = RLC_ST_IDLE; // R10
              end else if (!(r_reg.exc_seen || over_rec)) begin
                // Step up only while below recovery threshold, never past init
                r_next.gain.left = r_reg.gain.left + 1'b1; // R8 R4
                r_next.gain.right = r_reg.gain.right + 1'b1; // R8 R4
              end
              if (rec_mode == RLC_REC_LIMITED && r_next.exc_cnt == cnt_max)
                r_next.state = RLC_ST_IDLE; // R12
            end
          end
        end
        RLC_ST_ATTACK: begin
          if (r_reg.tmr == '0 && SAMPLE_VALID) begin
            if (over_atk) begin
              if (r_reg.gain.left != RLC_GAIN_MIN && r_reg.gain.right != RLC_GAIN_MIN) begin
                r_next.gain.left = r_reg.gain.left - 1'b1; // R2
                r_next.gain.right = r_reg.gain.right - 1'b1; // R2
              end // R19
              r_next.tmr = RLC_ATK_SAMPLES[atk_sel]; // R2
            end else if (rec_mode == RLC_REC_NONE || at_ceiling) begin
              r_next.state = RLC_ST_IDLE; // R6
            end else begin
              r_next.state = RLC_ST_RECOVER; // R8
              r_next.tmr = RLC_REC_SAMPLES[rec_sel];
            end
          end
        end
        default: r_next.state = RLC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      r_reg <= '{state: RLC_ST_IDLE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign WB_ACK_O = r_reg.ack;
  assign WB_DAT_O = r_reg.rdata;
  assign PGA_GAIN = r_reg.gain;
  assign SAMPLE_STROBE = r_reg.sstrobe;
  assign MOD_CLK_EN = r_reg.mod_en;
  assign DECIM_ALT_FILTER = r_reg.quarter; // R16

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_attack_hit;
    enable && r_reg.state != RLC_ST_ATTACK && over_atk && !(wr && WB_ADR_I == RLC_CTRL3_ADDR)
      && r_reg.en_prev && r_reg.gain.left != RLC_GAIN_MIN && r_reg.gain.right != RLC_GAIN_MIN;
  endsequence

  chk_attack_step: assert property (s_attack_hit |=> PGA_GAIN.left == $past(PGA_GAIN.left) - 1'b1
    && r_reg.state == RLC_ST_ATTACK) else $error("attack step missing"); // R1
  chk_gain_ceiling: assert property (PGA_GAIN.left <= r_reg.init.left
    && PGA_GAIN.right <= r_reg.init.right) else $error("gain above ceiling"); // R4
  chk_gain_diff: assert property (enable && r_reg.en_prev |->
    r_reg.init.left - PGA_GAIN.left == r_reg.init.right - PGA_GAIN.right)
    else $error("gain difference lost"); // R3
  chk_strobe_rate: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE [*8])
    else $error("sample strobe too fast"); // R14
  chk_ctrl3_reset: assert property (wr && WB_SEL_I[0] && WB_ADR_I == RLC_CTRL3_ADDR |=>
    PGA_GAIN == $past(r_reg.init)) else $error("control 3 write did not reset"); // R7
  chk_no_recover: assert property (enable && r_reg.en_prev && rec_mode == RLC_REC_NONE
    && !(wr && WB_ADR_I == RLC_CTRL3_ADDR) |=> PGA_GAIN.left <= $past(PGA_GAIN.left))
    else $error("gain recovered in no-recovery mode"); // R6
  chk_locked_write: assert property (enable && wr && WB_ADR_I == RLC_GAIN_L_ADDR |=>
    $stable(r_reg.init.left)) else $error("gain write accepted while enabled"); // R17
  chk_floor_sat: assert property (enable && PGA_GAIN.left == RLC_GAIN_MIN && r_reg.en_prev
    && !(wr && WB_ADR_I == RLC_CTRL3_ADDR) |=> PGA_GAIN.left == RLC_GAIN_MIN)
    else $error("gain wrapped below floor"); // R19
  chk_alt_filter: assert property (wr && WB_SEL_I[0] && WB_ADR_I == RLC_ADCCTL_ADDR |=> // R16
    DECIM_ALT_FILTER == $past(WB_DAT_I[RLC_AC_QUARTER])) else $error("filter select mismatch");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");

endmodule

// ### testbench/rlc_conv_model.sv
// Behavioural amplifier and record converter model feeding level samples
module rlc_conv_model
  import rlc_pkg::*;
#(
  parameter int GAP = 256
)(
  input wire logic clk,
  input wire logic rst,
  input wire rlc_gain_pair_t gain,
  input wire logic [RLC_LVL_W-1:0] amp_l,
  input wire logic [RLC_LVL_W-1:0] amp_r,
  output logic valid,
  output rlc_level_t level
);
  int cnt;
  // Linear stand-in: each gain code adds one threshold step to the magnitude
  // GAP below 256 compresses time so recovery intervals fit the run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      valid <= 1'b0;
      level <= '0;
    end else begin
      cnt <= (cnt == GAP-1) ? 0 : cnt + 1;
      valid <= (cnt == GAP-1);
      if (cnt == GAP-1) begin
        level.left <= amp_l + (RLC_LVL_W'(gain.left) << RLC_THR_SHIFT);
        level.right <= amp_r + (RLC_LVL_W'(gain.right) << RLC_THR_SHIFT);
      end else begin
        level <= ~level;  // Stale data must not look like a fresh sample
      end
    end
  end
endmodule

// ### testbench/testbench.sv
// Self-checking testbench for the record level control
module testbench
  import rlc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP = 2;
  // Scenarios select the shortest recovery interval, timer select 3
  localparam int REC = int'(RLC_REC_SAMPLES[3]) * GAP;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, valid, strobe, modc, alt;
  logic [RLC_LVL_W-1:0] amp_l = '0, amp_r = '0;
  rlc_level_t level;
  rlc_gain_pair_t pga;
  int err_total = 0, n_tests = 0, p;
  always #25 clk = ~clk;
  rlc_top i_rlc_top(.SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SAMPLE_VALID(valid), .SAMPLE_LEVEL(level), .PGA_GAIN(pga), .SAMPLE_STROBE(strobe),
    .MOD_CLK_EN(modc), .DECIM_ALT_FILTER(alt));
  rlc_conv_model #(.GAP(GAP)) i_rlc_conv_model(.clk(clk), .rst(rst), .gain(pga),
    .amp_l(amp_l), .amp_r(amp_r), .valid(valid), .level(level));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic gchk(input logic [5:0] l, input logic [5:0] r);
    chk(32'(pga), {20'h0, l, r});
  endtask
  // Request held until the edge that samples ack high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && t < 20) begin
      @(posedge clk);
      t++;
    end
    if (t >= 20) chk(32'h0, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic set_amp(input int l, input int r);
    amp_l <= RLC_LVL_W'(l) << RLC_THR_SHIFT;
    amp_r <= RLC_LVL_W'(r) << RLC_THR_SHIFT;
  endtask
  task automatic period(input bit s);
    int i;
    for (i = 0; i < 600 && !(s ? strobe : modc); i++) @(posedge clk);
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while (!(s ? strobe : modc) && p < 600);
  endtask
  // Settings only land while disabled, so drop enable first
  task automatic cfg(input logic [31:0] c1);
    set_amp(0, 0);
    wb(1, RLC_CTRL1_ADDR, 32'h0);
    wb(1, RLC_GAIN_L_ADDR, 32'h10);
    wb(1, RLC_GAIN_R_ADDR, 32'h0c);
    wb(1, RLC_CTRL2_ADDR, 32'h141e);
    wb(1, RLC_CTRL1_ADDR, c1 & 32'hfffe);
    wb(1, RLC_CTRL1_ADDR, c1);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    gchk(6'h00, 6'h00);
    wb(0, RLC_STATUS_ADDR, 32'h0);
    chk(q, 32'h1);
    wb(1, 8'hfc, 32'hffff);
    wb(0, 8'hfc, 32'h0);
    chk(q, 32'h0);
    wb(1, RLC_GAIN_L_ADDR, 32'h3f);
    wb(0, RLC_GAIN_L_ADDR, 32'h0);
    chk(q, 32'(RLC_GAIN_MAX));
  endtask
  task automatic t_clocks();
    period(1);
    chk(p, 256);
    period(0);
    chk(p, 2);
    wb(1, RLC_ADCCTL_ADDR, 32'h1);
    // A pulse launched under the old rate may still be in flight
    repeat (4) @(posedge clk);
    period(0);
    chk(p, 4);
    chk(alt, 1'b1);
    period(1);
    chk(p, 256);
    wb(1, RLC_ADCCTL_ADDR, 32'h0);
    repeat (3) @(posedge clk);
    chk(alt, 1'b0);
  endtask
  task automatic t_both();
    cfg(32'hf03);
    gchk(6'h10, 6'h0c);
    set_amp(20, 0);
    repeat (200) @(posedge clk);
    gchk(6'h10, 6'h0c);
    set_amp(20, 20);
    repeat (GAP + 3) @(posedge clk);
    gchk(6'h0f, 6'h0b);
    repeat (200) @(posedge clk);
    gchk(6'h0e, 6'h0a);
    set_amp(0, 0);
    repeat (2000) @(posedge clk);
    gchk(6'h0e, 6'h0a);
    wb(1, RLC_GAIN_L_ADDR, 32'h05);
    wb(1, RLC_CTRL3_ADDR, 32'h0);
    repeat (5) @(posedge clk);
    gchk(6'h10, 6'h0c);
  endtask
  task automatic t_normal();
    cfg(32'hf05);
    set_amp(20, 20);
    repeat (200) @(posedge clk);
    gchk(6'h0a, 6'h06);
    set_amp(15, 15);
    repeat (3 * REC) @(posedge clk);
    gchk(6'h0a, 6'h06);
    set_amp(0, 0);
    repeat (7 * REC) @(posedge clk);
    gchk(6'h10, 6'h0c);
    repeat (2 * REC) @(posedge clk);
    gchk(6'h10, 6'h0c);
  endtask
  task automatic t_limited();
    cfg(32'hf29);
    set_amp(20, 20);
    repeat (200) @(posedge clk);
    set_amp(15, 15);
    repeat (3 * REC) @(posedge clk);
    wb(0, RLC_STATUS_ADDR, 32'h0);
    chk(q, 32'h21);
    set_amp(0, 0);
    repeat (2 * REC) @(posedge clk);
    gchk(6'h0a, 6'h06);
    set_amp(25, 25);
    repeat (200) @(posedge clk);
    gchk(6'h05, 6'h01);
    wb(0, RLC_STATUS_ADDR, 32'h0);
    chk(q[7:4], 4'h0);
    set_amp(60, 60);
    repeat (200) @(posedge clk);
    gchk(6'h04, 6'h00);
  endtask
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_clocks();
    t_both();
    t_normal();
    t_limited();
    complete_run();
  end
  // About three and a half times the expected run length
  initial begin
    #3000000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
